//--- hw/cac_top.sv
// Clock alignment control registers with SPI slave and alignment-pulse path
// Operation
// - Control zero bit 6 enables the alignment processor; resets to zero.
// - Zoom bit 4 selects fine delay steps for windowing and position status.
// - Bits 3:0 of control zero select the alignment sampling delay.
// - Timestamp route bit plus general enable put pulse on sample LSB, D=1.
// - Control one bit 0 inverts alignment pulse polarity before use.
// - Bit 2 sets device clock, bit 1 alignment input, to PECL mode.
// - Control two bits 1:0 give one-hot sampling clock delay; reset 0x1.
// - Control two bit 2 enables supply noise suppression in clock path.
// - Control two bit 4 selects high converter feedback gain; resets 1.
// - Control two resets to 0x11; other two reset to zero.
// - A 24-bit read-only status reports alignment edge position.
// - All registers are reached only over the SPI register port.
`include "cac_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module cac_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // SPI register port
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  // Alignment pulse and timestamp context
  input wire logic align_pulse_in,
  input wire logic [23:0] align_capture_position,
  input wire logic general_timestamp_enable,
  input wire logic decimation_bypass,
  // Clock path configuration and alignment outputs
  output cac_pkg::cac_cfg_type cfg,
  output logic align_event,
  output logic timestamp_bit
);

  // Reset release through two flops
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire logic rst_i_n = rst_sync_reg;

  // Three-stage synchronisers; a change counts when stages two and three agree
  localparam int NSYNC = 4;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_stable;
  assign pin_raw = {spi_sclk, spi_cs_n, spi_sdi, align_pulse_in};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      logic [2:0] sh_reg;
      logic st_reg;
      always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
          sh_reg <= (gi == 2) ? 3'b111 : 3'b000;
          st_reg <= (gi == 2) ? 1'b1 : 1'b0;
        end else begin
          sh_reg <= {sh_reg[1:0], pin_raw[gi]};
          if (sh_reg[1] == sh_reg[2]) begin
            st_reg <= sh_reg[2];
          end
        end
      end
      assign pin_stable[gi] = st_reg;
    end
  endgenerate

  wire logic sclk_s = pin_stable[3];
  wire logic cs_n_s = pin_stable[2];
  wire logic sdi_s = pin_stable[1];
  wire logic pulse_s = pin_stable[0];

  // SPI frame: R/W bit, 15-bit address, then 8-bit data bytes streaming up
  logic sclk_d_reg;
  cac_pkg::cac_state_type state_reg, state_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [15:0] cmd_reg, cmd_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] rd_reg, rd_next;
  logic sdo_reg, sdo_next;
  logic [7:0] ctrl0_reg, ctrl0_next;
  logic [7:0] ctrl1_reg, ctrl1_next;
  logic [7:0] ctrl2_reg, ctrl2_next;

  wire logic rise = sclk_s & ~sclk_d_reg;
  wire logic fall = ~sclk_s & sclk_d_reg;

  // Read mux; reserved bits and unmapped addresses read zero
  function automatic logic [7:0] rd_mux(input logic [14:0] a,
                                        input logic [7:0] c0,
                                        input logic [7:0] c1,
                                        input logic [7:0] c2,
                                        input logic [23:0] pos);
    unique case (a)
      `CAC_ADDR_CTRL_ZERO: rd_mux = c0;
      `CAC_ADDR_CTRL_ONE: rd_mux = c1;
      `CAC_ADDR_CTRL_TWO: rd_mux = c2;
      `CAC_ADDR_POS_HI: rd_mux = pos[23:16];
      `CAC_ADDR_POS_MID: rd_mux = pos[15:8];
      `CAC_ADDR_POS_LO: rd_mux = pos[7:0];
      default: rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  // Next-state of SPI engine and register bank
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cmd_next = cmd_reg;
    sh_next = sh_reg;
    rd_next = rd_reg;
    sdo_next = sdo_reg;
    ctrl0_next = ctrl0_reg;
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    if (cs_n_s) begin
      state_next = cac_pkg::ST_CMD;
      cnt_next = 5'h00;
      sdo_next = 1'b0;
    end else begin
      unique case (state_reg)
        cac_pkg::ST_CMD: begin
          if (rise) begin
            cmd_next = {cmd_reg[14:0], sdi_s};
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == 5'h0f) begin
              state_next = cac_pkg::ST_DATA;
              cnt_next = 5'h00;
              rd_next = rd_mux(cmd_reg[13:0] == 14'h0000 ? 15'h0000 :
                {cmd_reg[13:0], sdi_s}, ctrl0_reg, ctrl1_reg,
                ctrl2_reg, align_capture_position);
            end
          end
        end
        cac_pkg::ST_DATA: begin
          // Read data shifts out MSB first on falling edges
          if (fall && cmd_reg[15]) begin
            sdo_next = rd_reg[7];
            rd_next = {rd_reg[6:0], 1'b0};
          end
          if (rise) begin
            sh_next = {sh_reg[6:0], sdi_s};
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == 5'h07) begin
              cnt_next = 5'h00;
              if (!cmd_reg[15]) begin
                // Writes mask reserved bits to zero
                unique case (cmd_reg[14:0])
                  `CAC_ADDR_CTRL_ZERO:
                    ctrl0_next = {sh_reg[6:0], sdi_s} & `CAC_MASK_CTRL_ZERO;
                  `CAC_ADDR_CTRL_ONE:
                    ctrl1_next = {sh_reg[6:0], sdi_s} & `CAC_MASK_CTRL_ONE;
                  `CAC_ADDR_CTRL_TWO:
                    ctrl2_next = {sh_reg[6:0], sdi_s} & `CAC_MASK_CTRL_TWO;
                  default: ;
                endcase
              end
              // Streaming: address ascends for the next byte
              cmd_next = {cmd_reg[15], cmd_reg[14:0] + 15'h0001};
              state_next = cac_pkg::ST_DONE;
            end
          end
        end
        cac_pkg::ST_DONE: begin
          state_next = cac_pkg::ST_DATA;
          rd_next = rd_mux(cmd_reg[14:0], ctrl0_reg, ctrl1_reg, ctrl2_reg,
            align_capture_position);
        end
        default: state_next = cac_pkg::ST_CMD;
      endcase
    end
  end

  // Register update; reset values per register
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      sclk_d_reg <= 1'b0;
      state_reg <= cac_pkg::ST_CMD;
      cnt_reg <= 5'h00;
      cmd_reg <= 16'h0000;
      sh_reg <= 8'h00;
      rd_reg <= 8'h00;
      sdo_reg <= 1'b0;
      ctrl0_reg <= `CAC_RST_CTRL_ZERO;
      ctrl1_reg <= `CAC_RST_CTRL_ONE;
      ctrl2_reg <= `CAC_RST_CTRL_TWO;
    end else begin
      sclk_d_reg <= sclk_s;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cmd_reg <= cmd_next;
      sh_reg <= sh_next;
      rd_reg <= rd_next;
      sdo_reg <= sdo_next;
      ctrl0_reg <= ctrl0_next;
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
    end
  end

  // Field decode into the configuration carrier
  cac_pkg::cac_cfg_type cfg_next;
  logic pulse_d_reg;
  logic pol_pulse;
  logic event_next;
  logic ts_next;
  always_comb begin
    cfg_next.align_processor_enable = ctrl0_reg[`CAC_BIT_PROC_EN];
    cfg_next.align_receiver_enable = ctrl0_reg[`CAC_BIT_RECV_EN];
    cfg_next.window_zoom = ctrl0_reg[`CAC_BIT_ZOOM];
    cfg_next.align_delay_select = ctrl0_reg[3:0];
    cfg_next.align_timestamp_route_enable = ctrl1_reg[`CAC_BIT_TS_ROUTE];
    cfg_next.device_clock_pecl_mode = ctrl1_reg[`CAC_BIT_DEVCLK_PECL];
    cfg_next.align_input_pecl_mode = ctrl1_reg[`CAC_BIT_ALIGN_PECL];
    cfg_next.align_polarity_invert = ctrl1_reg[`CAC_BIT_INVERT];
    cfg_next.feedback_gain_high = ctrl2_reg[`CAC_BIT_FB_GAIN];
    cfg_next.supply_noise_suppress = ctrl2_reg[`CAC_BIT_NOISE_SUPP];
    cfg_next.sampling_clock_delay = ctrl2_reg[1:0];
    // Inversion applies before edge detection so alignment uses polarity
    pol_pulse = pulse_s ^ ctrl1_reg[`CAC_BIT_INVERT];
    // Events only pass when receiver and processor are both on
    event_next = pol_pulse & ~pulse_d_reg & ctrl0_reg[`CAC_BIT_PROC_EN] &
      ctrl0_reg[`CAC_BIT_RECV_EN];
    ts_next = pol_pulse & ctrl1_reg[`CAC_BIT_TS_ROUTE] &
      general_timestamp_enable & decimation_bypass;
  end

  // Output registers
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      cfg <= '0;
      pulse_d_reg <= 1'b0;
      align_event <= 1'b0;
      timestamp_bit <= 1'b0;
    end else begin
      cfg <= cfg_next;
      pulse_d_reg <= pol_pulse;
      align_event <= event_next;
      timestamp_bit <= ts_next;
    end
  end

  assign spi_sdo = sdo_reg;

endmodule : cac_top
`default_nettype wire

//--- hw/cac_regs.svh
// Register offsets, field positions, reset values for clock alignment control
`ifndef CAC_REGS_SVH
`define CAC_REGS_SVH

`define CAC_ADDR_CTRL_ZERO 15'h0029
`define CAC_ADDR_CTRL_ONE 15'h002a
`define CAC_ADDR_CTRL_TWO 15'h002b
`define CAC_ADDR_POS_HI 15'h002c
`define CAC_ADDR_POS_MID 15'h002d
`define CAC_ADDR_POS_LO 15'h002e

`define CAC_RST_CTRL_ZERO 8'h00
`define CAC_RST_CTRL_ONE 8'h00
`define CAC_RST_CTRL_TWO 8'h11

`define CAC_MASK_CTRL_ZERO 8'h7f
`define CAC_MASK_CTRL_ONE 8'h0f
`define CAC_MASK_CTRL_TWO 8'h17

`define CAC_BIT_PROC_EN 6
`define CAC_BIT_RECV_EN 5
`define CAC_BIT_ZOOM 4
`define CAC_BIT_TS_ROUTE 3
`define CAC_BIT_DEVCLK_PECL 2
`define CAC_BIT_ALIGN_PECL 1
`define CAC_BIT_INVERT 0
`define CAC_BIT_FB_GAIN 4
`define CAC_BIT_NOISE_SUPP 2

`endif

//--- hw/cac_pkg.sv
// Types for the clock alignment control register bank
package cac_pkg;

  // Decoded configuration driven into the clock path
  typedef struct packed {
    logic align_processor_enable;
    logic align_receiver_enable;
    logic window_zoom;
    logic [3:0] align_delay_select;
    logic align_timestamp_route_enable;
    logic device_clock_pecl_mode;
    logic align_input_pecl_mode;
    logic align_polarity_invert;
    logic feedback_gain_high;
    logic supply_noise_suppress;
    logic [1:0] sampling_clock_delay;
  } cac_cfg_type;

  // SPI frame state
  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_DATA = 2'b01,
    ST_DONE = 2'b10
  } cac_state_type;

endpackage : cac_pkg

//--- verification/cac_checker.sv
// Port assertions for the clock alignment control register bank
`timescale 1ns/1ps
`default_nettype none
module cac_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Observed ports
  input wire logic spi_cs_n,
  input wire logic general_timestamp_enable,
  input wire logic decimation_bypass,
  input wire cac_pkg::cac_cfg_type cfg,
  input wire logic align_event,
  input wire logic timestamp_bit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Event and cfg leave the same control registers on the same edge
  proc_gate_a: assert property (align_event |->
    cfg.align_processor_enable) else $error("event, processor off");
  recv_gate_a: assert property (align_event |->
    cfg.align_receiver_enable) else $error("event, receiver off");
  event_pulse_a: assert property (align_event |=> !align_event)
    else $error("event longer than one cycle");
  // Context levels are registered once, so the bit lags them by one cycle
  ts_gate_a: assert property (timestamp_bit |->
    $past(general_timestamp_enable)) else $error("timestamp, enable off");
  ts_bypass_a: assert property (timestamp_bit |->
    $past(decimation_bypass)) else $error("timestamp, no bypass");
  ts_route_a: assert property (timestamp_bit |->
    cfg.align_timestamp_route_enable) else $error("timestamp, route off");
  // Reset state shows on cfg a few cycles after the release
  two_reset_a: assert property ($rose(rst_n) |-> ##6
    (cfg.feedback_gain_high && cfg.sampling_clock_delay == 2'h1
    && !cfg.supply_noise_suppress)) else $error("control two reset value");
  zero_reset_a: assert property ($rose(rst_n) |-> ##6
    cfg[14:4] == 11'h000) else $error("control zero or one not cleared");
  // Configuration only moves through a serial frame
  cfg_quiet_a: assert property (spi_cs_n [*8] |=> $stable(cfg))
    else $error("cfg changed outside a frame");
  cover property (align_event);
  cover property (timestamp_bit);
  cover property ($fell(spi_cs_n));
  cover property (align_event && cfg.align_polarity_invert);
endmodule : cac_checker
bind cac_top cac_checker cac_checker_inst (.clk(clk), .rst_n(rst_n),
  .spi_cs_n(spi_cs_n), .general_timestamp_enable(general_timestamp_enable),
  .decimation_bypass(decimation_bypass), .cfg(cfg),
  .align_event(align_event), .timestamp_bit(timestamp_bit));
`default_nettype wire

//--- verification/cac_align_src.sv
// External source of the alignment pulse
`timescale 1ns/1ps
`default_nettype none
module cac_align_src (
  // Clock and trigger
  input wire logic clk,
  input wire logic fire,
  // Pulse toward the device
  output logic align_pulse
);
  logic [7:0] left_reg = 8'h00;
  // Long level so the device's sync stages never miss it
  always_ff @(posedge clk) begin
    if (fire) begin
      left_reg <= 8'h28;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end
  assign align_pulse = (left_reg != 8'h00);
endmodule : cac_align_src
`default_nettype wire

//--- verification/test_clock_alignment_ctrl_regs.sv
// Self-checking bench for the clock alignment control register bank
`include "cac_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_clock_alignment_ctrl_regs;
  logic clk, rst_n, sclk, cs_n, sdi, sdo, fire, pulse, gen_ts, bypass;
  logic align_event, timestamp_bit;
  logic [23:0] pos;
  logic [7:0] rd, v;
  logic [15:0] rd2;
  logic [7:0] m [3];
  logic [7:0] msk [3];
  cac_pkg::cac_cfg_type cfg;
  int mismatches, compares, seed, h, l, t;
  cac_top cac_top_inst (.clk(clk), .rst_n(rst_n), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo), .align_pulse_in(pulse),
    .align_capture_position(pos), .general_timestamp_enable(gen_ts),
    .decimation_bypass(bypass), .cfg(cfg), .align_event(align_event),
    .timestamp_bit(timestamp_bit));
  cac_align_src cac_align_src_inst (.clk(clk), .fire(fire),
    .align_pulse(pulse));
  function automatic cac_pkg::cac_cfg_type ex(input logic [7:0] a, b, c);
    return cac_pkg::cac_cfg_type'({a[6:0], b[3:0], c[4], c[2], c[1:0]});
  endfunction : ex
  task automatic chk(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask : ticks
  // Mode 0 frame of n bits, half period of six clocks to clear the syncs
  task automatic frame(input logic [31:0] sh, input int n);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = sh[i];
      ticks(6);
      if (i < 16) rd2[i] = sdo;
      sclk = 1'b1;
      ticks(6);
      sclk = 1'b0;
    end
    ticks(6);
    cs_n = 1'b1;
    ticks(12);
  endtask : frame
  // Single-byte access; read data lands in rd
  task automatic spi(input logic rw, input logic [14:0] a, input logic [7:0] d);
    frame({8'h00, rw, a, d}, 24);
    rd = rd2[7:0];
  endtask : spi
  // Program enables, fire one pulse, count events per pulse phase
  task automatic pulse_run(input logic [7:0] c0, c1, input int eh, el, et);
    spi(1'b0, `CAC_ADDR_CTRL_ZERO, 8'h00);
    spi(1'b0, `CAC_ADDR_CTRL_ONE, c1);
    // Receiver comes up first; delay select stays zero for calibration
    spi(1'b0, `CAC_ADDR_CTRL_ZERO, c0 & 8'h20);
    spi(1'b0, `CAC_ADDR_CTRL_ZERO, c0);
    fire = 1'b1;
    ticks(1);
    fire = 1'b0;
    {h, l, t} = '0;
    for (int i = 0; i < 80; i++) begin
      ticks(1);
      if (i < 40) h += align_event;
      else l += align_event;
      t += timestamp_bit;
    end
    chk("events while high", h, eh);
    chk("events after fall", l, el);
    chk("timestamp seen", t != 0, et);
  endtask : pulse_run
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst_n, sclk, sdi, fire, gen_ts, bypass} = 6'h00;
    cs_n = 1'b1;
    pos = 24'h00_0000;
    {mismatches, compares} = '0;
    seed = 32'h0000_9372;
    m = '{8'h00, 8'h00, 8'h11};
    msk = '{`CAC_MASK_CTRL_ZERO, `CAC_MASK_CTRL_ONE, `CAC_MASK_CTRL_TWO};
    ticks(5);
    rst_n = 1'b1;
    ticks(10);
    // Reset values, then all-ones, all-zeros and random writes
    for (int r = 0; r < 3; r++) begin
      spi(1'b1, `CAC_ADDR_CTRL_ZERO + 15'(r), 8'h00);
      chk("reset value", rd, m[r]);
    end
    chk("cfg after reset", cfg, ex(m[0], m[1], m[2]));
    for (int k = 0; k < 15; k++) begin
      // Random writes keep reserved bits zero; all-ones corner probes masks
      v = 8'($random(seed)) & msk[k % 3];
      if (k < 6) v = (k < 3) ? 8'hff : 8'h00;
      spi(1'b0, `CAC_ADDR_CTRL_ZERO + 15'(k % 3), v);
      m[k % 3] = v & msk[k % 3];
      spi(1'b1, `CAC_ADDR_CTRL_ZERO + 15'(k % 3), 8'h00);
      chk("readback", rd, m[k % 3]);
      chk("cfg fields", cfg, ex(m[0], m[1], m[2]));
    end
    // Streaming pair: the address steps up after each byte
    v = 8'($random(seed)) & msk[1];
    frame({1'b0, `CAC_ADDR_CTRL_ZERO, 8'h35, v}, 32);
    m[0] = 8'h35;
    m[1] = v;
    frame({1'b1, `CAC_ADDR_CTRL_ZERO, 16'h0000}, 32);
    chk("stream byte zero", rd2[15:8], m[0]);
    chk("stream byte one", rd2[7:0], m[1]);
    chk("stream cfg", cfg, ex(m[0], m[1], m[2]));
    // Unmapped and read-only targets leave the bank alone
    spi(1'b0, 15'h0028, 8'hff);
    spi(1'b0, `CAC_ADDR_POS_HI, 8'hff);
    chk("cfg untouched", cfg, ex(m[0], m[1], m[2]));
    pos = 24'($random(seed));
    for (int r = 0; r < 3; r++) begin
      spi(1'b1, `CAC_ADDR_POS_HI + 15'(r), 8'h00);
      chk("position byte", rd, pos[23 - 8 * r -: 8]);
    end
    pulse_run(8'h60, 8'h00, 1, 0, 0);
    pulse_run(8'h20, 8'h00, 0, 0, 0);
    pulse_run(8'h40, 8'h00, 0, 0, 0);
    pulse_run(8'h70, 8'h00, 1, 0, 0);
    pulse_run(8'h60, 8'h01, 0, 1, 0);
    for (int g = 0; g < 8; g++) begin
      gen_ts = g[0];
      bypass = g[1];
      pulse_run(8'h60, g[2] ? 8'h08 : 8'h00, 1, 0, g == 7);
    end
    // Reset in mid-run restores the documented defaults
    rst_n = 1'b0;
    ticks(3);
    rst_n = 1'b1;
    ticks(10);
    chk("cfg after rerun", cfg, ex(8'h00, 8'h00, 8'h11));
    complete_run();
  end
endmodule : test_clock_alignment_ctrl_regs
`default_nettype wire
